// File: inc/chg_pkg.sv
// Package with charger supervisor states, timer counts and status codes
package chg_pkg;
  typedef enum logic [3:0] {
    CHG_OFF, CHG_CHECK, CHG_START, CHG_PRE, CHG_CC, CHG_ABS, CHG_FLOAT,
    CHG_PRE_SUSP, CHG_CC_SUSP, CHG_ABS_SUSP, CHG_FLOAT_SUSP, CHG_FAULT
  } chg_state_t;

  localparam logic [21:0] CHG_ABS_TIMEOUT = 22'h1fffff;
  localparam int unsigned CHG_TMR_DIV     = 8;
  localparam logic [21:0] CHG_PRE_TIMEOUT = CHG_ABS_TIMEOUT / 22'(CHG_TMR_DIV);
  localparam int unsigned CHG_TMR_W       = 22;
  localparam int unsigned CHG_SYNC_W      = 10;
  localparam int unsigned CHG_START_NS    = 1000;
  localparam int unsigned CHG_CLK_NS      = 10;
  localparam int unsigned CHG_START_CYC   = (CHG_START_NS + CHG_CLK_NS - 1) / CHG_CLK_NS;
  localparam int unsigned CHG_START_W     = 8;
  localparam logic [1:0]  CHG_CODE_OFF    = 2'h3;
  localparam logic [1:0]  CHG_CODE_CHG    = 2'h2;
  localparam logic [1:0]  CHG_CODE_FLOAT  = 2'h0;
  localparam logic [1:0]  CHG_CODE_FAULT  = 2'h1;
  localparam int unsigned CHG_IDX_DD      = 0;
  localparam int unsigned CHG_IDX_FB_CV   = 1;
  localparam int unsigned CHG_IDX_FB_LOW  = 2;
  localparam int unsigned CHG_IDX_TEMP    = 3;
  localparam int unsigned CHG_IDX_REF     = 4;
  localparam int unsigned CHG_IDX_GATE    = 5;
  localparam int unsigned CHG_IDX_TAPER   = 6;
  localparam int unsigned CHG_IDX_HWF     = 7;
  localparam int unsigned CHG_IDX_TDIS    = 8;
  localparam int unsigned CHG_IDX_TMR     = 9;
endpackage

// File: rtl/chg_sync.sv
// Two-flop synchroniser bank for asynchronous sense inputs
`timescale 1ns/100ps
module chg_sync
  import chg_pkg::*;
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_ce,
  input  wire logic [CHG_SYNC_W-1:0] i_async,
  output logic      [CHG_SYNC_W-1:0] o_sync
);
  logic [CHG_SYNC_W-1:0] meta_q;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else if (i_ce) begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// File: rtl/chg_supervisor.sv
// Lead-acid charger supervisor: charge states, safety timer, status flags, faults
// Function
// - Timer disabled setting: no counting, no timeout transitions anywhere.
// - Timer advances only in precharge and absorption states.
// - Precharge limit equals absorption count divided by 8.
// - Absorption timeout after 2097151 timer oscillator cycles.
// - Precharge timeout before battery rises above 1.26V gives latched fault.
// - Absorption timeout pulls high flag low and enters float.
// - Two open-drain flags form 2-bit code, high flag first.
// - Code 11 when off, 10 while precharge, CC or absorption.
// - Code 00 in float, 01 in fault or temperature suspend.
// - Power-up check hardware faults latch until power cycle.
// - Reference window, gate drive or low feedback latch fault in any state after the power-up check.
// - Battery below 1.25V in absorption or float latches fault.
// - Temperature outside window suspends charging and pauses timer.
// - Back in window resumes state; timer resumes except CC and float.
// - Temperature suspend is not latched; clears by itself.
// - After startup delay enter precharge if battery low, else CC.
// - Precharge exit above 1.26V clears timer, enters CC.
// - CC exits to absorption when feedback above CV threshold.
// - Taper current in absorption resets timer, high flag low, float.
`timescale 1ns/100ps
module chg_supervisor
  import chg_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  input  wire logic i_enable,
  input  wire logic i_deep_discharge_sense,
  input  wire logic i_feedback_cv,
  input  wire logic i_feedback_low,
  input  wire logic i_temp_out_of_window,
  input  wire logic i_ref_out_of_window,
  input  wire logic i_gate_drive_ok,
  input  wire logic i_taper_current_reached,
  input  wire logic i_hw_fault_check,
  input  wire logic i_timer_disabled,
  input  wire logic i_timer_oscillator_input,
  output logic      o_status_flag_high_bit_oe,
  output logic      o_status_flag_low_bit_oe,
  output logic      o_status_flag_high_bit,
  output logic      o_status_flag_low_bit,
  output logic      o_converter_run,
  output logic      o_fault
);
  logic [CHG_SYNC_W-1:0]  sense_s;
  chg_state_t             state_q;
  chg_state_t             state_d;
  logic [CHG_TMR_W-1:0]   tmr_cnt_q;
  logic                   tmr_osc_q;
  logic                   tmr_edge;
  logic                   tmr_run;
  logic                   tmr_clear;
  logic [CHG_START_W-1:0] start_cnt_q;
  logic [1:0]             code_q;
  logic                   en_meta_q;
  logic                   en_q;
  logic                   dd_above, fb_cv, fb_low, temp_bad, ref_bad, gate_ok, taper;
  logic                   hw_fault, tdis, run_fault, pre_to, abs_to;

  chg_sync u_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_async    ({i_timer_oscillator_input, i_timer_disabled, i_hw_fault_check,
                  i_taper_current_reached, i_gate_drive_ok, i_ref_out_of_window,
                  i_temp_out_of_window, i_feedback_low, i_feedback_cv,
                  i_deep_discharge_sense}),
    .o_sync     (sense_s)
  );

  assign dd_above = sense_s[CHG_IDX_DD];
  assign fb_cv    = sense_s[CHG_IDX_FB_CV];
  assign fb_low   = sense_s[CHG_IDX_FB_LOW];
  assign temp_bad = sense_s[CHG_IDX_TEMP];
  assign ref_bad  = sense_s[CHG_IDX_REF];
  assign gate_ok  = sense_s[CHG_IDX_GATE];
  assign taper    = sense_s[CHG_IDX_TAPER];
  assign hw_fault = sense_s[CHG_IDX_HWF];
  assign tdis     = sense_s[CHG_IDX_TDIS];

  // Enable pin is asynchronous too: own two flops
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      en_meta_q <= 1'b0;
      en_q      <= 1'b0;
    end else if (i_ce) begin
      en_meta_q <= i_enable;
      en_q      <= en_meta_q;
    end
  end

  // Rising edge of synchronised oscillator
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tmr_osc_q <= 1'b0;
    end else if (i_ce) begin
      tmr_osc_q <= sense_s[CHG_IDX_TMR];
    end
  end
  assign tmr_edge = sense_s[CHG_IDX_TMR] & ~tmr_osc_q;

  assign tmr_run = ~tdis & ((state_q == CHG_PRE) | (state_q == CHG_ABS));
  assign pre_to  = ~tdis & (state_q == CHG_PRE) & (tmr_cnt_q >= CHG_PRE_TIMEOUT);
  assign abs_to  = ~tdis & (state_q == CHG_ABS) & (tmr_cnt_q >= CHG_ABS_TIMEOUT);
  assign run_fault = ref_bad | ~gate_ok | fb_low;

  always_comb begin
    state_d   = state_q;
    tmr_clear = 1'b0;
    case (state_q)
      CHG_OFF: begin
        if (en_q) begin
          state_d = CHG_CHECK;
        end
      end
      CHG_CHECK: begin
        if (hw_fault) begin
          state_d = CHG_FAULT;
        end else begin
          state_d = CHG_START;
        end
      end
      CHG_START: begin
        if (hw_fault) begin
          state_d = CHG_FAULT;
        end else if (start_cnt_q == CHG_START_W'(CHG_START_CYC - 1)) begin
          state_d   = dd_above ? CHG_CC : CHG_PRE;
          tmr_clear = 1'b1;
        end
      end
      CHG_PRE: begin
        if (dd_above) begin
          state_d   = CHG_CC;
          tmr_clear = 1'b1;
        end else if (pre_to) begin
          state_d = CHG_FAULT;
        end else if (temp_bad) begin
          state_d = CHG_PRE_SUSP;
        end
      end
      CHG_CC: begin
        if (temp_bad) begin
          state_d = CHG_CC_SUSP;
        end else if (fb_cv) begin
          state_d = CHG_ABS;
        end
      end
      CHG_ABS: begin
        if (!dd_above) begin
          state_d = CHG_FAULT;
        end else if (taper || abs_to) begin
          state_d   = CHG_FLOAT;
          tmr_clear = 1'b1;
        end else if (temp_bad) begin
          state_d = CHG_ABS_SUSP;
        end
      end
      CHG_FLOAT: begin
        if (!dd_above) begin
          state_d = CHG_FAULT;
        end else if (temp_bad) begin
          state_d = CHG_FLOAT_SUSP;
        end
      end
      CHG_PRE_SUSP:   if (!temp_bad) state_d = CHG_PRE;
      CHG_CC_SUSP:    if (!temp_bad) state_d = CHG_CC;
      CHG_ABS_SUSP:   if (!temp_bad) state_d = CHG_ABS;
      CHG_FLOAT_SUSP: if (!temp_bad) state_d = CHG_FLOAT;
      CHG_FAULT: state_d = CHG_FAULT;
      default:   state_d = CHG_FAULT;
    endcase
    if (state_q != CHG_OFF && state_q != CHG_CHECK && state_q != CHG_FAULT && run_fault) begin
      state_d = CHG_FAULT;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= CHG_OFF;
    end else if (i_ce) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      start_cnt_q <= '0;
    end else if (i_ce) begin
      start_cnt_q <= (state_q == CHG_START) ? start_cnt_q + 1'b1 : '0;
    end
  end

  // Safety timer holds its count through suspend states
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tmr_cnt_q <= '0;
    end else if (i_ce) begin
      if (tmr_clear) begin
        tmr_cnt_q <= '0;
      end else if (tmr_run && tmr_edge && tmr_cnt_q != CHG_ABS_TIMEOUT) begin
        tmr_cnt_q <= tmr_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      code_q <= CHG_CODE_OFF;
    end else if (i_ce) begin
      case (state_d)
        CHG_OFF, CHG_CHECK, CHG_START: code_q <= CHG_CODE_OFF;
        CHG_PRE, CHG_CC, CHG_ABS:      code_q <= CHG_CODE_CHG;
        CHG_FLOAT:                     code_q <= CHG_CODE_FLOAT;
        default:                       code_q <= CHG_CODE_FAULT;
      endcase
    end
  end

  assign o_status_flag_high_bit    = 1'b0;
  assign o_status_flag_low_bit     = 1'b0;
  assign o_status_flag_high_bit_oe = ~code_q[1];
  assign o_status_flag_low_bit_oe  = ~code_q[0];
  assign o_converter_run = (state_q == CHG_PRE) | (state_q == CHG_CC) |
                           (state_q == CHG_ABS) | (state_q == CHG_FLOAT);
  assign o_fault = (state_q == CHG_FAULT);
endmodule

// File: dv/chg_supervisor_sva.sv
// Checker for charger supervisor status codes and fault latching
`timescale 1ns/100ps
module chg_supervisor_sva (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_deep_discharge_sense,
  input wire logic i_temp_out_of_window,
  input wire logic i_ref_out_of_window,
  input wire logic i_gate_drive_ok,
  input wire logic i_feedback_low,
  input wire logic o_status_flag_high_bit_oe,
  input wire logic o_status_flag_low_bit_oe,
  input wire logic o_status_flag_high_bit,
  input wire logic o_status_flag_low_bit,
  input wire logic o_converter_run,
  input wire logic o_fault
);
  wire hi  = o_status_flag_high_bit_oe;
  wire lo  = o_status_flag_low_bit_oe;
  wire run = o_converter_run;
  wire bad = i_ref_out_of_window || i_feedback_low || !i_gate_drive_ok;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  pins_low_a: assert property (!o_status_flag_high_bit && !o_status_flag_low_bit)
    else $error("flag pin driven high");
  fault_code_a: assert property (o_fault |-> hi && !lo && !run)
    else $error("fault code wrong");
  fault_hold_a: assert property (o_fault |=> o_fault)
    else $error("fault left");
  charge_code_a: assert property (run |-> lo)
    else $error("charge code wrong");
  idle_code_a: assert property (!hi && !run |-> !lo)
    else $error("off code wrong");
  run_fault_a: assert property (run && bad |-> ##[1:4] o_fault)
    else $error("running fault missed");
  float_dd_a: assert property (
    (run && hi && !i_deep_discharge_sense && !i_temp_out_of_window)[*3] |-> ##[0:2] o_fault)
    else $error("low battery missed");
  temp_susp_a: assert property (run && i_temp_out_of_window |-> ##[1:6] !run)
    else $error("no suspend");
  temp_resume_a: assert property (
    (!o_fault && hi && !lo && !i_temp_out_of_window)[*4] |-> ##[0:3] (run || o_fault))
    else $error("no resume");
endmodule

bind chg_supervisor chg_supervisor_sva chg_supervisor_sva_inst (
  .i_core_clk                (i_core_clk),
  .i_rst                     (i_rst),
  .i_deep_discharge_sense    (i_deep_discharge_sense),
  .i_temp_out_of_window      (i_temp_out_of_window),
  .i_ref_out_of_window       (i_ref_out_of_window),
  .i_gate_drive_ok           (i_gate_drive_ok),
  .i_feedback_low            (i_feedback_low),
  .o_status_flag_high_bit_oe (o_status_flag_high_bit_oe),
  .o_status_flag_low_bit_oe  (o_status_flag_low_bit_oe),
  .o_status_flag_high_bit    (o_status_flag_high_bit),
  .o_status_flag_low_bit     (o_status_flag_low_bit),
  .o_converter_run           (o_converter_run),
  .o_fault                   (o_fault)
);

// File: dv/chg_sense_model.sv
// Far side: free-running timer oscillator and gate drive sense
`timescale 1ns/100ps
module chg_sense_model #(
  parameter int HALF_NS = 37
) (
  input  wire logic i_short,
  output logic      o_timer_oscillator_input,
  output logic      o_gate_drive_ok
);
  initial begin
    o_timer_oscillator_input = 1'b0;
    forever #(HALF_NS) o_timer_oscillator_input = ~o_timer_oscillator_input;
  end
  assign o_gate_drive_ok = ~i_short;
endmodule

// File: dv/chg_supervisor_test.sv
// Self-checking bench for the charger supervisor
`timescale 1ns/100ps
module chg_supervisor_test;
  logic        i_core_clk, i_rst, i_ce, i_enable, i_deep_discharge_sense, i_feedback_cv;
  logic        i_feedback_low, i_temp_out_of_window, i_ref_out_of_window, i_hw_fault_check;
  logic        i_taper_current_reached, i_timer_disabled, i_timer_oscillator_input;
  logic        i_gate_drive_ok, gate_short, o_converter_run, o_fault;
  logic        o_status_flag_high_bit_oe, o_status_flag_low_bit_oe;
  logic        o_status_flag_high_bit, o_status_flag_low_bit;
  logic [3:0]  exp_q[$];
  logic [3:0]  prev, cur;
  logic [31:0] seed = 32'h60253b63;
  int          error_cnt, checks;

  chg_supervisor chg_supervisor_inst (
    .i_core_clk                (i_core_clk),
    .i_rst                     (i_rst),
    .i_ce                      (i_ce),
    .i_enable                  (i_enable),
    .i_deep_discharge_sense    (i_deep_discharge_sense),
    .i_feedback_cv             (i_feedback_cv),
    .i_feedback_low            (i_feedback_low),
    .i_temp_out_of_window      (i_temp_out_of_window),
    .i_ref_out_of_window       (i_ref_out_of_window),
    .i_gate_drive_ok           (i_gate_drive_ok),
    .i_taper_current_reached   (i_taper_current_reached),
    .i_hw_fault_check          (i_hw_fault_check),
    .i_timer_disabled          (i_timer_disabled),
    .i_timer_oscillator_input  (i_timer_oscillator_input),
    .o_status_flag_high_bit_oe (o_status_flag_high_bit_oe),
    .o_status_flag_low_bit_oe  (o_status_flag_low_bit_oe),
    .o_status_flag_high_bit    (o_status_flag_high_bit),
    .o_status_flag_low_bit     (o_status_flag_low_bit),
    .o_converter_run           (o_converter_run),
    .o_fault                   (o_fault)
  );
  chg_sense_model chg_sense_model_inst (
    .i_short                  (gate_short),
    .o_timer_oscillator_input (i_timer_oscillator_input),
    .o_gate_drive_ok          (i_gate_drive_ok)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  always @(negedge i_core_clk) begin
    seed = lfsr(seed);
    i_timer_disabled <= seed[0];
  end

  task automatic cmp_status(input logic [3:0] exp, input logic [3:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value status exp %b got %b", exp, got);
    end
  endtask

  // Result is {pin levels, run, fault}; pins read high when released
  always @(negedge i_core_clk) begin
    cur = {~o_status_flag_high_bit_oe, ~o_status_flag_low_bit_oe, o_converter_run, o_fault};
    if (cur !== prev) begin
      if (exp_q.size() == 0) cmp_status(4'hf, cur);
      else cmp_status(exp_q.pop_front(), cur);
    end
    prev = cur;
  end

  task automatic step(input logic [3:0] exp);
    int n = 0;
    exp_q.push_back(exp);
    while (exp_q.size() != 0 && n < 300) begin
      @(negedge i_core_clk);
      n++;
    end
    if (n == 300) cmp_status(exp, 4'hx);
  endtask

  task automatic restart();
    exp_q.push_back(4'hc);
    i_rst = 1'b1;
    {i_enable, i_deep_discharge_sense, i_feedback_cv, i_feedback_low, i_hw_fault_check} = '0;
    {i_temp_out_of_window, i_ref_out_of_window, i_taper_current_reached, gate_short} = '0;
    repeat (20) @(negedge i_core_clk);
    i_rst = 1'b0;
  endtask

  task automatic complete_run();
    if (exp_q.size() != 0) error_cnt++;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end

  initial begin
    i_ce = 1'b1;
    i_timer_disabled = 1'b0;
    restart();
    i_enable = 1'b1;
    // Clock enable low: start-up must not proceed
    i_ce = 1'b0;
    repeat (120) @(negedge i_core_clk);
    i_ce = 1'b1;
    step(4'ha);
    i_temp_out_of_window = 1'b1;
    step(4'h4);
    i_temp_out_of_window = 1'b0;
    step(4'ha);
    i_deep_discharge_sense = 1'b1;
    i_feedback_cv = 1'b1;
    repeat (10) @(negedge i_core_clk);
    i_temp_out_of_window = 1'b1;
    step(4'h4);
    i_temp_out_of_window = 1'b0;
    step(4'ha);
    i_taper_current_reached = 1'b1;
    step(4'h2);
    i_deep_discharge_sense = 1'b0;
    step(4'h5);
    i_enable = 1'b0;
    i_temp_out_of_window = 1'b1;
    repeat (20) @(negedge i_core_clk);
    for (int k = 0; k < 4; k++) begin
      restart();
      i_deep_discharge_sense = 1'b1;
      i_hw_fault_check = (k == 3);
      i_enable = 1'b1;
      if (k < 3) step(4'ha);
      gate_short = (k == 0);
      i_ref_out_of_window = (k == 1);
      i_feedback_low = (k == 2);
      step(4'h5);
    end
    complete_run();
  end
endmodule
